// ### design/lpsr_pkg.sv
package lpsr_pkg;

  // word and lane geometry
  localparam int unsigned WORD_W         = 28;
  localparam int unsigned LANES          = 4;
  localparam int unsigned SLOTS          = 7;
  localparam int unsigned SLOT_W         = 3;
  localparam int unsigned CLK_HIGH_SLOTS = 4;
  localparam int unsigned FIFO_DEPTH     = 16;

  // first and last slot of a pixel period
  localparam logic [2:0] SLOT_FIRST = 3'h0;
  localparam logic [2:0] SLOT_LAST  = 3'h6;

  // parallel bit carried by each lane in each serial slot, lane 0 first
  localparam int unsigned SLOT_MAP [SLOTS][LANES] = '{
    '{ 1,  9, 20,  5},
    '{ 0,  8, 19, 27},
    '{ 7, 18, 26, 23},
    '{ 6, 15, 25, 17},
    '{ 4, 14, 24, 16},
    '{ 3, 13, 22, 11},
    '{ 2, 12, 21, 10}
  };

  // positions of the control bits that the host places in the word
  localparam int unsigned HSYNC_BIT = 24;
  localparam int unsigned VSYNC_BIT = 25;
  localparam int unsigned DE_BIT    = 26;

  // timing at the system clock rate
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned LOCK_TIME_US    = 6;
  localparam int unsigned LOCK_CYCLES     =
    (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DISABLE_TIME_NS = 7;
  localparam int unsigned DISABLE_CYCLES  =
    (DISABLE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : DISABLE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned LOCK_CNT_W      = 10;

  // reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 28'h0000000;
  localparam logic [LANES-1:0]  LANE_RESET = 4'h0;

  typedef enum logic {LPSR_IDLE, LPSR_RUN} lpsr_link_state_t;

endpackage

// ### design/lpsr_serializer.sv
`timescale 1ns/100ps
`default_nettype none

// dual-clock fifo, gray pointers cross between the domains
module lpsr_async_fifo #(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             wr_clk,
  input  wire logic             resetn,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_clk,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin;
  logic [AW:0]      wgray;
  logic [AW:0]      rbin;
  logic [AW:0]      rgray;
  logic [AW:0]      rgray_w1;
  logic [AW:0]      rgray_w2;
  logic [AW:0]      wgray_r1;
  logic [AW:0]      wgray_r2;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // full when the write pointer is one lap ahead of the read pointer
  assign wr_ready = (wgray != {~rgray_w2[AW:AW-1], rgray_w2[AW-2:0]});
  assign rd_valid = (rgray != wgray_r2);
  assign rd_data  = mem[rbin[AW-1:0]];

  // storage, written only on an accepted push
  always_ff @(posedge wr_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wbin[AW-1:0]] <= wr_data;
    end
  end

  // write pointer
  always_ff @(posedge wr_clk or negedge resetn) begin
    if (!resetn) begin
      wbin  <= '0;
      wgray <= '0;
    end else if (wr_valid && wr_ready) begin
      wbin  <= wbin + 1'b1;
      wgray <= to_gray(wbin + 1'b1);
    end
  end

  // read pointer
  always_ff @(posedge rd_clk or negedge resetn) begin
    if (!resetn) begin
      rbin  <= '0;
      rgray <= '0;
    end else if (rd_valid && rd_ready) begin
      rbin  <= rbin + 1'b1;
      rgray <= to_gray(rbin + 1'b1);
    end
  end

  // pointer synchronisers, first stage read only by the second
  always_ff @(posedge wr_clk or negedge resetn) begin
    if (!resetn) begin
      rgray_w1 <= '0;
      rgray_w2 <= '0;
    end else begin
      rgray_w1 <= rgray;
      rgray_w2 <= rgray_w1;
    end
  end

  always_ff @(posedge rd_clk or negedge resetn) begin
    if (!resetn) begin
      wgray_r1 <= '0;
      wgray_r2 <= '0;
    end else begin
      wgray_r1 <= wgray;
      wgray_r2 <= wgray_r1;
    end
  end

endmodule // lpsr_async_fifo

// Overview of operation
// - slot 0 puts bits 1, 9, 20, 5 on lanes 0 to 3.
// - slot 1 puts bits 0, 8, 19, 27 on lanes 0 to 3.
// - slot 2 puts bits 7, 18, 26, 23 on lanes 0 to 3.
// - slot 3 puts bits 6, 15, 25, 17 on lanes 0 to 3.
// - slot 4 puts bits 4, 14, 24, 16 on lanes 0 to 3.
// - slot 5 puts bits 3, 13, 22, 11 on lanes 0 to 3.
// - slot 6 puts bits 2, 12, 21, 10 on lanes 0 to 3.
// - slot k starts k sevenths after forwarded clock rise; slot 0 on the rise.
// - forwarded clock has pixel period, high for four of seven slots.
// - lanes valid only after lock time following power-down release.
// - power-down asserted puts lanes and forwarded clock in high impedance quickly.
// - each lane runs seven bits per pixel period, one slice per word.
// - capture parallel word on pixel clock edge chosen by edge select.
module lpsr_serializer
  import lpsr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              link_clk,
  input  wire logic              pixel_clock_in,
  input  wire logic              capture_edge_select,
  input  wire logic              power_down_n,
  input  wire logic [WORD_W-1:0] parallel_bit,
  output logic                   capture_ready,
  output logic                   link_locked,
  output logic [LANES-1:0]       serial_data_lane,
  output logic                   serial_data_lane_oe,
  output logic                   forwarded_link_clock,
  output logic                   forwarded_link_clock_oe
);

  // ---- system clock side: pin synchronisers ----
  logic              pclk_s1;
  logic              pclk_s2;
  logic              pclk_s3;
  logic              sel_s1;
  logic              sel_s2;
  logic              pdn_s1;
  logic              pdn_s2;
  logic [WORD_W-1:0] data_s1;
  logic [WORD_W-1:0] data_s2;
  logic [LOCK_CNT_W-1:0] lock_cnt;
  logic              locked;
  logic              cap_valid;
  logic [WORD_W-1:0] cap_word;
  logic              cap_edge;
  logic              fifo_wr_ready;

  // ---- link side ----
  logic              lk_lock_s1;
  logic              lk_lock_s2;
  logic              lk_pdn_s1;
  logic              lk_pdn_s2;
  logic              link_active;
  lpsr_link_state_t  link_state;
  logic [SLOT_W-1:0] slot;
  logic [SLOT_W-1:0] out_slot;
  logic [WORD_W-1:0] cur_word;
  logic              fifo_rd_valid;
  logic              fifo_rd_ready;
  logic [WORD_W-1:0] fifo_rd_data;

  // lane bits of one slot, looked up from the slot map
  function automatic logic [LANES-1:0] slot_bits(input logic [WORD_W-1:0] w,
                                                 input logic [SLOT_W-1:0] s);
    logic [LANES-1:0] r;
    r = LANE_RESET;
    for (int l = 0; l < LANES; l++) begin
      r[l] = w[SLOT_MAP[s][l]];
    end
    slot_bits = r;
  endfunction

  // every asynchronous pin passes two flops before anything looks at it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pclk_s1 <= 1'b0;
      pclk_s2 <= 1'b0;
      pclk_s3 <= 1'b0;
      sel_s1  <= 1'b0;
      sel_s2  <= 1'b0;
      pdn_s1  <= 1'b0;
      pdn_s2  <= 1'b0;
      data_s1 <= WORD_RESET;
      data_s2 <= WORD_RESET;
    end else begin
      pclk_s1 <= pixel_clock_in;
      pclk_s2 <= pclk_s1;
      pclk_s3 <= pclk_s2;
      sel_s1  <= capture_edge_select;
      sel_s2  <= sel_s1;
      pdn_s1  <= power_down_n;
      pdn_s2  <= pdn_s1;
      data_s1 <= parallel_bit;
      data_s2 <= data_s1;
    end
  end

  // select high takes the rising edge, low the falling edge
  assign cap_edge = sel_s2 ? (pclk_s2 && !pclk_s3) : (!pclk_s2 && pclk_s3);

  // lock timer stands in for the clock multiplier settling after release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_cnt <= '0;
      locked   <= 1'b0;
    end else if (!pdn_s2) begin
      lock_cnt <= '0;
      locked   <= 1'b0;
    end else if (lock_cnt == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
      locked   <= 1'b1;
    end else begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // capture one word per selected edge; nothing is taken before lock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_valid <= 1'b0;
      cap_word  <= WORD_RESET;
    end else begin
      cap_valid <= cap_edge && locked;
      if (cap_edge) begin
        cap_word <= data_s2;
      end
    end
  end

  // full fifo means the link runs slower than the pixel clock
  assign capture_ready = fifo_wr_ready;

  lpsr_async_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .wr_clk   (clk),
    .resetn   (resetn),
    .wr_valid (cap_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (cap_word),
    .rd_clk   (link_clk),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data)
  );

  // lock and power-down into the link domain; power-down also directly
  // so the drivers drop without waiting on the system clock path
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      lk_lock_s1 <= 1'b0;
      lk_lock_s2 <= 1'b0;
      lk_pdn_s1  <= 1'b0;
      lk_pdn_s2  <= 1'b0;
    end else begin
      lk_lock_s1 <= locked;
      lk_lock_s2 <= lk_lock_s1;
      lk_pdn_s1  <= power_down_n;
      lk_pdn_s2  <= lk_pdn_s1;
    end
  end

  assign link_active = lk_lock_s2 && lk_pdn_s2;
  assign link_locked = lk_lock_s2;

  // idle drains stale words so a fresh lock starts from new data
  assign fifo_rd_ready = (link_state == LPSR_IDLE) || (slot == SLOT_LAST);

  // link state: idle while powered down or unlocked
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      link_state <= LPSR_IDLE;
    end else begin
      case (link_state)
        LPSR_IDLE: begin
          if (link_active) begin
            link_state <= LPSR_RUN;
          end
        end
        LPSR_RUN: begin
          if (!link_active) begin
            link_state <= LPSR_IDLE;
          end
        end
        default: link_state <= LPSR_IDLE;
      endcase
    end
  end

  // slot counter; parked on the last slot so the first active edge loads
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      slot <= SLOT_LAST;
    end else if (!link_active) begin
      slot <= SLOT_LAST;
    end else if (slot == SLOT_LAST) begin
      slot <= SLOT_FIRST;
    end else begin
      slot <= slot + 1'b1;
    end
  end

  // word register: a new word enters each period; underrun sends zeros
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      cur_word <= WORD_RESET;
    end else if (!link_active) begin
      cur_word <= WORD_RESET;
    end else if (slot == SLOT_LAST) begin
      cur_word <= fifo_rd_valid ? fifo_rd_data : WORD_RESET;
    end
  end

  // lane and forwarded clock flops share one edge, so slot 0 meets the rise
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      serial_data_lane     <= LANE_RESET;
      forwarded_link_clock <= 1'b0;
      out_slot             <= SLOT_LAST;
    end else if (link_state == LPSR_RUN && link_active) begin
      serial_data_lane     <= slot_bits(cur_word, slot);
      forwarded_link_clock <= (slot < SLOT_W'(CLK_HIGH_SLOTS));
      out_slot             <= slot;
    end else begin
      serial_data_lane     <= LANE_RESET;
      forwarded_link_clock <= 1'b0;
      out_slot             <= SLOT_LAST;
    end
  end

  // drivers enabled only while running; low means high impedance outside
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      serial_data_lane_oe     <= 1'b0;
      forwarded_link_clock_oe <= 1'b0;
    end else begin
      serial_data_lane_oe     <= (link_state == LPSR_RUN) && link_active;
      forwarded_link_clock_oe <= (link_state == LPSR_RUN) && link_active;
    end
  end

  // ---- checks ----
  sequence clk_high4_s;
    forwarded_link_clock [*4];
  endsequence

  sequence clk_low3_s;
    (!forwarded_link_clock) [*3];
  endsequence

  slot0_map_a: assert property (@(posedge link_clk) disable iff (!resetn)
    serial_data_lane_oe && out_slot == 3'h0 |-> serial_data_lane ==
      {$past(cur_word[5]), $past(cur_word[20]), $past(cur_word[9]), $past(cur_word[1])})
    else $error("slot 0 lane bits wrong");
  slot1_map_a: assert property (@(posedge link_clk) disable iff (!resetn)
    serial_data_lane_oe && out_slot == 3'h1 |-> serial_data_lane ==
      {$past(cur_word[27]), $past(cur_word[19]), $past(cur_word[8]), $past(cur_word[0])})
    else $error("slot 1 lane bits wrong");
  slot2_map_a: assert property (@(posedge link_clk) disable iff (!resetn)
    serial_data_lane_oe && out_slot == 3'h2 |-> serial_data_lane ==
      {$past(cur_word[23]), $past(cur_word[26]), $past(cur_word[18]), $past(cur_word[7])})
    else $error("slot 2 lane bits wrong");
  slot3_map_a: assert property (@(posedge link_clk) disable iff (!resetn)
    serial_data_lane_oe && out_slot == 3'h3 |-> serial_data_lane ==
      {$past(cur_word[17]), $past(cur_word[25]), $past(cur_word[15]), $past(cur_word[6])})
    else $error("slot 3 lane bits wrong");
  slot4_map_a: assert property (@(posedge link_clk) disable iff (!resetn)
    serial_data_lane_oe && out_slot == 3'h4 |-> serial_data_lane ==
      {$past(cur_word[16]), $past(cur_word[24]), $past(cur_word[14]), $past(cur_word[4])})
    else $error("slot 4 lane bits wrong");
  slot5_map_a: assert property (@(posedge link_clk) disable iff (!resetn)
    serial_data_lane_oe && out_slot == 3'h5 |-> serial_data_lane ==
      {$past(cur_word[11]), $past(cur_word[22]), $past(cur_word[13]), $past(cur_word[3])})
    else $error("slot 5 lane bits wrong");
  slot6_map_a: assert property (@(posedge link_clk) disable iff (!resetn)
    serial_data_lane_oe && out_slot == 3'h6 |-> serial_data_lane ==
      {$past(cur_word[10]), $past(cur_word[21]), $past(cur_word[12]), $past(cur_word[2])})
    else $error("slot 6 lane bits wrong");

  clock_rise_slot_a: assert property (@(posedge link_clk) disable iff (!resetn)
    $rose(forwarded_link_clock) |-> out_slot == 3'h0)
    else $error("forwarded clock rose off slot 0");

  // a power-down drops the drivers mid-period, so the shape is only owed while driven
  clock_shape_a: assert property (@(posedge link_clk)
    disable iff (!resetn || !serial_data_lane_oe)
    $rose(forwarded_link_clock) |-> clk_high4_s ##1 clk_low3_s)
    else $error("forwarded clock not four high three low");

  period_seven_a: assert property (@(posedge link_clk) disable iff (!resetn)
    $rose(forwarded_link_clock) ##1 link_active [*7] |-> $rose(forwarded_link_clock))
    else $error("pixel period not seven slots");

  lock_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(locked) |-> pdn_s2 && lock_cnt == LOCK_CNT_W'(LOCK_CYCLES - 1))
    else $error("lock declared before the lock time");

  disable_fast_a: assert property (@(posedge link_clk) disable iff (!resetn)
    !lk_pdn_s2 |=> !serial_data_lane_oe && !forwarded_link_clock_oe)
    else $error("drivers still on after power-down");

  capture_edge_a: assert property (@(posedge clk) disable iff (!resetn)
    cap_valid |-> cap_word == $past(data_s2) &&
      ($past(sel_s2) ? $past(pclk_s2 && !pclk_s3) : $past(!pclk_s2 && pclk_s3)))
    else $error("word captured off the selected edge");

  word_load_a: assert property (@(posedge link_clk) disable iff (!resetn)
    link_active && $past(link_active) && $past(slot) == SLOT_LAST |-> slot == SLOT_FIRST &&
      cur_word == ($past(fifo_rd_valid) ? $past(fifo_rd_data) : WORD_RESET))
    else $error("word not loaded at period boundary");

  restart_slot_a: assert property (@(posedge link_clk) disable iff (!resetn)
    !link_active |=> slot == SLOT_LAST && cur_word == WORD_RESET && !serial_data_lane_oe)
    else $error("state kept across power-down");

endmodule // lpsr_serializer

`default_nettype wire

// ### test/lpsr_rx_model.sv
`timescale 1ns/100ps
`default_nettype none

// receiving panel: rebuilds each word from the lanes, aligned on the rise of lane_oe; the forwarded clock is only checked
module lpsr_rx_model
  import lpsr_pkg::*;
(
  input  wire logic             link_clk,
  input  wire logic             resetn,
  input  wire logic [LANES-1:0] lane_pin,
  input  wire logic             lane_oe,
  input  wire logic             fwd_pin,
  input  wire logic             fwd_oe,
  output logic                  word_valid,
  output logic [WORD_W-1:0]     word,
  output int                    n_err
);
  logic [LANES-1:0]  lane_last;
  logic              fwd_last;
  logic              oe_q;
  int                slot;
  logic [WORD_W-1:0] acc;

  // a released pin shows the inverse of its last level, so a stale bit never passes
  wire logic [LANES-1:0] lane_wire = lane_oe ? lane_pin : ~lane_last;
  wire logic             fwd_wire  = fwd_oe ? fwd_pin : ~fwd_last;

  // sample mid-bit on the falling edge, where registered outputs are settled
  always @(negedge link_clk or negedge resetn) begin
    if (!resetn) begin
      word_valid = 1'b0;
      word = '0;
      n_err = 0;
      oe_q = 1'b0;
      slot = 0;
      lane_last = '0;
      fwd_last = 1'b0;
      acc = '0;
    end else begin
      word_valid = 1'b0;
      if (lane_oe !== fwd_oe) n_err++;
      if (lane_oe === 1'b1) begin
        slot = (oe_q === 1'b1) ? (slot + 1) % SLOTS : 0;
        if (fwd_wire !== (slot < CLK_HIGH_SLOTS)) n_err++;
        for (int l = 0; l < LANES; l++) acc[SLOT_MAP[slot][l]] = lane_wire[l];
        if (slot == SLOTS - 1) begin
          word = acc;
          word_valid = 1'b1;
        end
      end
      oe_q = lane_oe;
      lane_last = lane_wire;
      fwd_last = fwd_wire;
    end
  end
endmodule // lpsr_rx_model

`default_nettype wire

// ### test/lvds_pixel_serializer_28to4_bench.sv
`timescale 1ns/100ps
`default_nettype none

`define CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected %s expected %0h seen %0h", what, exp, got); end end

module lvds_pixel_serializer_28to4_bench;
  import lpsr_pkg::*;
  logic              clk = 1'b0;
  logic              link_src = 1'b0;
  wire logic         link_clk;
  logic              resetn = 1'b0;
  logic              pixel_clock_in = 1'b0;
  logic              capture_edge_select = 1'b1;
  logic              power_down_n = 1'b1;
  logic [WORD_W-1:0] parallel_bit = '0;
  logic              capture_ready;
  logic              link_locked;
  logic [LANES-1:0]  lanes;
  logic              lane_oe;
  logic              fwd;
  logic              fwd_oe;
  logic              rx_valid;
  logic [WORD_W-1:0] rx_word;
  int                rx_err;
  int                n_fail = 0;
  int                n_compared = 0;
  int                seed = 20;
  logic              saw_full = 1'b0;
  logic [WORD_W-1:0] exp_q [$];

  // the link clock is shifted so its edges never meet the system clock's
  always #5 clk = ~clk;
  always #15 link_src = ~link_src;
  assign #7.3 link_clk = link_src;

  lpsr_serializer DUT (.clk(clk), .resetn(resetn), .link_clk(link_clk),
    .pixel_clock_in(pixel_clock_in), .capture_edge_select(capture_edge_select),
    .power_down_n(power_down_n), .parallel_bit(parallel_bit),
    .capture_ready(capture_ready), .link_locked(link_locked),
    .serial_data_lane(lanes), .serial_data_lane_oe(lane_oe),
    .forwarded_link_clock(fwd), .forwarded_link_clock_oe(fwd_oe));

  lpsr_rx_model rx (.link_clk(link_clk), .resetn(resetn), .lane_pin(lanes),
    .lane_oe(lane_oe), .fwd_pin(fwd), .fwd_oe(fwd_oe), .word_valid(rx_valid),
    .word(rx_word), .n_err(rx_err));

  // all-zero words are underrun fill or burst padding and carry nothing to compare
  always @(posedge link_clk) begin
    if (rx_valid === 1'b1 && rx_word !== '0) begin
      if (exp_q.size() == 0) `CHECK("spare word", 28'h0000000, rx_word)
      else begin
        `CHECK("word", exp_q[0], rx_word)
        void'(exp_q.pop_front());
      end
    end
  end

  always @(posedge clk) if (capture_ready === 1'b0) saw_full <= 1'b1;

  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one pixel period of 2*half+1 clk; data moves on the edge that does not capture
  task automatic pixel(input logic [WORD_W-1:0] w, input int half);
    @(negedge clk);
    pixel_clock_in = ~capture_edge_select;
    parallel_bit = w;
    repeat (half) @(negedge clk);
    pixel_clock_in = capture_edge_select;
    repeat (half) @(negedge clk);
  endtask

  // lanes stay off well into the lock time, then come up within a bounded wait
  task automatic power_up;
    int n;
    repeat (550) @(negedge clk);
    `CHECK("oe during lock", 1'b0, lane_oe)
    `CHECK("locked during lock", 1'b0, link_locked)
    n = 0;
    while (lane_oe !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) begin
      n_fail++;
      results();
    end
    `CHECK("locked", 1'b1, link_locked)
  endtask

  task automatic traffic(input int count, input logic flush);
    logic [WORD_W-1:0] w;
    repeat (3) pixel(28'h0000000, 10);
    repeat (count) begin
      w = WORD_W'($random(seed));
      w[DE_BIT] = 1'b1;
      exp_q.push_back(w);
      pixel(w, 10);
    end
    if (flush) begin
      repeat (20) pixel(28'h0000000, 10);
      `CHECK("words left", 0, exp_q.size())
    end
  endtask

  initial begin
    int n;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    power_up();
    traffic(12, 1'b1);
    $display("test rising capture done");
    // power-down in mid-stream; whatever was in flight is thrown away
    traffic(5, 1'b0);
    power_down_n = 1'b0;
    n = 0;
    while (lane_oe !== 1'b0 && n < 12) begin
      @(negedge clk);
      n++;
    end
    `CHECK("oe off", 1'b0, lane_oe)
    `CHECK("clock oe off", 1'b0, fwd_oe)
    // drivers that never drop leave nothing sensible to test after this point
    if (lane_oe !== 1'b0) results();
    exp_q.delete();
    capture_edge_select = 1'b0;
    repeat (50) @(negedge clk);
    `CHECK("oe held off", 1'b0, lane_oe)
    power_down_n = 1'b1;
    power_up();
    traffic(12, 1'b1);
    $display("test power-down and falling capture done");
    // burst faster than the link drains until the buffer refuses
    repeat (40) pixel(28'h0000000, 3);
    `CHECK("buffer refused", 1'b1, saw_full)
    repeat (400) @(negedge clk);
    `CHECK("buffer drained", 1'b1, capture_ready)
    traffic(8, 1'b1);
    $display("test buffer fill done");
    `CHECK("link timing errors", 0, rx_err)
    results();
  end
endmodule // lvds_pixel_serializer_28to4_bench

`default_nettype wire
